// ==== design/hptd_pkg.sv ====
// Purpose: Shared constants for the heater power telecommand link.
// Assumes: Packets move as 16-bit words, first word first, on one clock.
// Notes: Field positions count from the most significant bit of each word.
package hptd_pkg;
    localparam int WORDS = 7;                         // Packet length in 16-bit words.
    localparam logic [2:0] VERSION = 3'h0;
    localparam logic [0:0] TC_TYPE = 1'h1;
    localparam logic [0:0] DFH_FLAG = 1'h1;
    localparam logic [6:0] APID = 7'h47;
    localparam logic [3:0] CATEGORY = 4'hC;
    localparam logic [1:0] SEQ_FLAGS = 2'h3;
    localparam logic [2:0] SEQ_SOURCE = 3'h0;
    localparam logic [15:0] LENGTH = 16'h0007;
    localparam logic [2:0] SVC_VERSION = 3'h0;
    localparam logic [0:0] CKSUM_FLAG = 1'h1;
    localparam logic [3:0] ACK = 4'h1;
    localparam logic [7:0] PKT_TYPE = 8'hC0;
    localparam logic [7:0] SUBTYPE = 8'h65;
    localparam logic [7:0] PAD = 8'h00;
    localparam logic [15:0] DATA_OFF = 16'h0000;
    localparam logic [15:0] DATA_ON = 16'h0001;
    localparam logic [15:0] CKSUM_SEED = 16'hFFFF;
    localparam logic [6:0] CTRL_ADDR = 7'h64;         // Control register address 100.
    localparam int CTRL_HEATER_BIT = 14;
    localparam int HK_HEATER_BIT = 9;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Host register offsets.
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_SEQ = 4'h2;
endpackage

// ==== design/hptd_link_if.sv ====
// Purpose: Word link from command computer to instrument decoder.
// Assumes: One clock shared by both ends.
// Notes: A word passes when valid and ready are both high.
`timescale 1ns/1ns
interface hptd_link_if;
    logic valid;
    logic ready;
    logic [15:0] data;
    logic last;
    logic restart;
    modport host (output valid, output data, output last, output restart, input ready);
    modport dev (input valid, input data, input last, input restart, output ready);
endinterface

// ==== design/hptd_cksum.sv ====
// Purpose: Running 16-bit packet checksum over words.
// Assumes: Caller clears it on the last word of each packet.
// Notes: Rotate-and-xor sum; same module at both ends.
`timescale 1ns/1ns
module hptd_cksum
    import hptd_pkg::*;
(
    input wire logic clk_sys_i,       // System clock.
    input wire logic rst_n_i,         // Synchronous reset, active low.
    input wire logic clear_i,         // Restart the sum.
    input wire logic add_i,           // Fold in word_i.
    input wire logic [15:0] word_i,   // Word to add.
    output logic [15:0] sum_o         // Current sum.
);
    typedef struct packed {
        logic [15:0] sum;
    } hptd_ck_t;
    hptd_ck_t s_q, s_d;

    // Clear takes priority so a new packet never inherits an old sum.
    always_comb begin
        s_d = s_q;
        if (clear_i) begin
            s_d.sum = CKSUM_SEED;
        end else if (add_i) begin
            s_d.sum = {s_q.sum[14:0], s_q.sum[15]} ^ word_i;
        end
    end

    // State register.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_q <= '{sum: CKSUM_SEED};
        end else begin
            s_q <= s_d;
        end
    end

    assign sum_o = s_q.sum;
endmodule // hptd_cksum

// ==== design/hptd_dev.sv ====
// Purpose: Instrument end: decodes heater power telecommands.
// Assumes: Words arrive first to last; last marks the checksum word.
// Notes: Any bad field or checksum drops the packet with a reject_o pulse.
// Notes on behaviour
// RL1: APID 1000111, category 1100, fixed bits checked.
// RL2: Sequence count top three bits zero.
// RL3: Sender counts per APID and category.
// RL4: Length field must equal seven.
// RL5: Service version 000, checksum flag set.
// RL6: Acknowledge field must be 0001.
// RL7: Packet type must be 192.
// RL8: Subtype 101 after zero pad selects heater; code puts subtype in the high byte and the zero pad after it.
// RL9: Data 0 means off, 1 means on.
// RL10: Apply accepted setting immediately.
// RL11: Write control address 100 bit 14 only.
// RL12: Housekeeping bit 9 mirrors heater state.
// RL13: Reset and restart force heater off.
// RL14: Bad checksum or header discards packet.
// RL15: Data other than 0 or 1 ignored.
`timescale 1ns/1ns
module hptd_dev
    import hptd_pkg::*;
(
    input wire logic clk_sys_i,           // System clock.
    input wire logic rst_n_i,             // Synchronous reset, active low.
    hptd_link_if.dev link,                // Command link.
    output logic heater_en_o,             // Heater drive, high = on.
    output logic [15:0] control_address_register_o, // Control register 100.
    output logic [15:0] control_status_housekeeping_word_o, // Housekeeping word.
    output logic accept_o,                // One-cycle pulse on accepted command.
    output logic reject_o                 // One-cycle pulse on dropped packet.
);
    typedef struct packed {
        logic [2:0] idx;
        logic bad;
        logic [15:0] value;
        logic [15:0] ctrl;
        logic accept;
        logic reject;
    } hptd_dev_t;
    hptd_dev_t s_q, s_d;
    logic [15:0] sum;
    logic take;
    logic word_ok;
    logic [15:0] w;

    assign take = link.valid;   // Always ready; no stall needed at this rate.
    assign link.ready = 1'b1;
    assign w = link.data;

    hptd_cksum u_ck (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clear_i(take && link.last),
        .add_i(take && !link.last),
        .word_i(w),
        .sum_o(sum)
    );

    // Per-word field checks.
    always_comb begin
        word_ok = 1'b0;
        case (s_q.idx)
            3'h0: word_ok = (w[15:13] == VERSION) && (w[12] == TC_TYPE) && // see RL1
                (w[11] == DFH_FLAG) && (w[10:4] == APID) && (w[3:0] == CATEGORY);
            3'h1: word_ok = (w[15:14] == SEQ_FLAGS) && (w[13:11] == SEQ_SOURCE); // see RL2
            3'h2: word_ok = (w == LENGTH); // see RL4
            3'h3: word_ok = (w[15:13] == SVC_VERSION) && (w[12] == CKSUM_FLAG) && // see RL5
                (w[11:8] == ACK) && (w[7:0] == PKT_TYPE); // see RL6 see RL7
            3'h4: word_ok = (w[15:8] == SUBTYPE) && (w[7:0] == PAD); // see RL8
            3'h5: word_ok = (w == DATA_OFF) || (w == DATA_ON); // see RL9 see RL15
            3'h6: word_ok = (w == sum); // see RL14
            default: word_ok = 1'b0;
        endcase
    end

    // Packet walk; a short or long packet is judged bad at its last word.
    always_comb begin
        s_d = s_q;
        s_d.accept = 1'b0;
        s_d.reject = 1'b0;
        if (take) begin
            if (s_q.idx == 3'h5) begin
                s_d.value = w;
            end
            if (link.last) begin
                s_d.idx = 3'h0;
                s_d.bad = 1'b0;
                if (!s_q.bad && word_ok && s_q.idx == 3'(WORDS - 1)) begin // see RL14
                    s_d.ctrl[CTRL_HEATER_BIT] = s_q.value[0]; // see RL10 see RL11
                    s_d.accept = 1'b1;
                end else begin
                    s_d.reject = 1'b1;
                end
            end else begin
                s_d.bad = s_q.bad || !word_ok || (s_q.idx == 3'(WORDS - 1));
                if (s_q.idx != 3'(WORDS - 1)) begin
                    s_d.idx = s_q.idx + 3'h1;
                end
            end
        end
        if (link.restart) begin
            s_d.ctrl[CTRL_HEATER_BIT] = 1'b0; // see RL13
            s_d.idx = 3'h0;
            s_d.bad = 1'b0;
        end
    end

    // State register; reset puts the heater off.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_q <= '{idx: 3'h0, bad: 1'b0, value: 16'h0000, ctrl: CTRL_RESET, // see RL13
                     accept: 1'b0, reject: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign heater_en_o = s_q.ctrl[CTRL_HEATER_BIT];
    assign control_address_register_o = s_q.ctrl;
    // Only the heater bit is modelled in the housekeeping word.
    always_comb begin
        control_status_housekeeping_word_o = 16'h0000;
        control_status_housekeeping_word_o[HK_HEATER_BIT] = s_q.ctrl[CTRL_HEATER_BIT]; // see RL12
    end
    assign accept_o = s_q.accept;
    assign reject_o = s_q.reject;
endmodule // hptd_dev

// ==== design/hptd_host.sv ====
// Purpose: Command computer end: builds heater power telecommands.
// Assumes: Software writes commands through a plain register port.
// Notes: One packet in flight; a heater command while busy is dropped, a restart still goes out.
`timescale 1ns/1ns
module hptd_host
    import hptd_pkg::*;
(
    input wire logic clk_sys_i,           // System clock.
    input wire logic rst_n_i,             // Synchronous reset, active low.
    hptd_link_if.host link,               // Command link.
    input wire logic [3:0] addr_i,        // Register address.
    input wire logic [15:0] wdata_i,      // Write data.
    input wire logic wr_i,                // Write strobe.
    input wire logic rd_i,                // Read strobe.
    output logic [15:0] rdata_o           // Read data, cycle after rd_i.
);
    typedef struct packed {
        logic busy;
        logic [2:0] idx;
        logic [15:0] data;
        logic [10:0] seq;
        logic restart;
        logic dropped;
        logic [15:0] rdata;
    } hptd_host_t;
    hptd_host_t s_q, s_d;
    logic [15:0] sum;
    logic [15:0] word;
    logic fire;

    assign fire = s_q.busy && link.ready;

    hptd_cksum u_ck (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clear_i(fire && s_q.idx == 3'(WORDS - 1)),
        .add_i(fire && s_q.idx != 3'(WORDS - 1)),
        .word_i(word),
        .sum_o(sum)
    );

    // Word assembly in send order.
    always_comb begin
        case (s_q.idx)
            3'h0: word = {VERSION, TC_TYPE, DFH_FLAG, APID, CATEGORY}; // see RL1
            3'h1: word = {SEQ_FLAGS, SEQ_SOURCE, s_q.seq}; // see RL2
            3'h2: word = LENGTH; // see RL4
            3'h3: word = {SVC_VERSION, CKSUM_FLAG, ACK, PKT_TYPE}; // see RL5 see RL6 see RL7
            3'h4: word = {SUBTYPE, PAD}; // see RL8
            3'h5: word = s_q.data; // see RL9
            default: word = sum;
        endcase
    end

    // Command port and sequencing; the counter serves this one APID/category pair.
    always_comb begin
        s_d = s_q;
        s_d.restart = 1'b0;
        s_d.rdata = 16'h0000;
        if (fire) begin
            if (s_q.idx == 3'(WORDS - 1)) begin
                s_d.busy = 1'b0;
                s_d.idx = 3'h0;
                s_d.seq = s_q.seq + 11'h001; // see RL3
            end else begin
                s_d.idx = s_q.idx + 3'h1;
            end
        end
        if (wr_i && addr_i == REG_CMD) begin
            if (wdata_i[15]) begin
                s_d.restart = 1'b1;
            end else if (s_q.busy) begin
                s_d.dropped = 1'b1;
            end else begin
                s_d.busy = 1'b1;
                s_d.data = {15'h0000, wdata_i[0]}; // see RL9
            end
        end
        if (wr_i && addr_i == REG_STAT && wdata_i[1] && !s_d.dropped) begin
            s_d.dropped = 1'b0;
        end else if (wr_i && addr_i == REG_STAT && wdata_i[1] && !(wr_i && addr_i == REG_CMD)) begin
            s_d.dropped = 1'b0;
        end
        if (rd_i) begin
            case (addr_i)
                REG_STAT: s_d.rdata = {14'h0000, s_q.dropped, s_q.busy};
                REG_SEQ: s_d.rdata = {5'h00, s_q.seq};
                default: s_d.rdata = 16'h0000;
            endcase
        end
    end

    // State register; counter starts at zero.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_q <= '{busy: 1'b0, idx: 3'h0, data: 16'h0000, seq: 11'h000, // see RL2
                     restart: 1'b0, dropped: 1'b0, rdata: 16'h0000};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.valid = s_q.busy;
    assign link.data = word;
    assign link.last = (s_q.idx == 3'(WORDS - 1));
    assign link.restart = s_q.restart;
    assign rdata_o = s_q.rdata;
endmodule // hptd_host

// ==== test/hptd_properties.sv ====
// Purpose: Timing checks on the heater command link and decoder.
// Assumes: One clock; inputs are link wires and decoder outputs.
// Notes: Decoder answers each packet with a one-cycle pulse.
`timescale 1ns/1ns
module hptd_properties
    import hptd_pkg::*;
(
    input wire logic clk_sys_i, // Clock.
    input wire logic rst_n_i, // Reset.
    input wire logic valid, // Word valid.
    input wire logic last, // Last word.
    input wire logic restart, // Restart.
    input wire logic [15:0] data, // Word.
    input wire logic heater_en_o, // Heater.
    input wire logic [15:0] control_address_register_o, // Control.
    input wire logic [15:0] control_status_housekeeping_word_o, // Status.
    input wire logic accept_o, // Accepted.
    input wire logic reject_o // Dropped.
);
    // One clock domain, so clock and reset are stated once.
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Status and control copies must track the drive with no lag.
    hk_mirror_a:
        assert property (control_status_housekeeping_word_o == {6'h00, heater_en_o, 9'h000})
        else $error("Status bit wrong");
    ctrl_bit_a:
        assert property (control_address_register_o == {1'h0, heater_en_o, 14'h0000})
        else $error("Control bit wrong");
    // The heater moves only on an accept or after a restart.
    heater_cause_a: assert property (!$stable(heater_en_o) |-> accept_o || $past(restart))
        else $error("Heater moved alone");
    reject_hold_a: assert property (reject_o |-> $stable(heater_en_o))
        else $error("Drop moved heater");
    restart_off_a: assert property (restart |=> !heater_en_o)
        else $error("Restart left heater on");
    accept_data_a:
        assert property (accept_o |-> $past(valid && last) && heater_en_o == $past(data[0], 2))
        else $error("Accept data wrong");
    // Framing seen on the wire: seven words, fixed header fields.
    frame_len_a:
        assert property ($rose(valid) |-> (valid && !last)[*6] ##1 (valid && last))
        else $error("Frame length wrong");
    head_word_a:
        assert property ($rose(valid) |-> data == {VERSION, TC_TYPE, DFH_FLAG, APID, CATEGORY})
        else $error("Header word wrong");
    seq_word_a: assert property ($rose(valid) |=> data[15:11] == 5'h18)
        else $error("Sequence source wrong");
endmodule // hptd_properties

// ==== test/tb_heater_power_telecommand_decoder.sv ====
// Purpose: Self-checking bench for both ends of the heater command link.
// Assumes: 25 MHz clock; a hand driver feeds a second decoder.
// Notes: Each bad row spoils one field, so only good rows may act.
`timescale 1ns/1ns
module tb_heater_power_telecommand_decoder
    import hptd_pkg::*;
;
    typedef struct packed {logic ok; logic [2:0] ix; logic [15:0] mk;} hptd_row_t;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdat = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdat;
    logic ht [2];
    logic acc [2];
    logic rej [2];
    logic [15:0] ctl [2];
    logic [15:0] hk [2];
    logic [15:0] pk [7];
    logic [15:0] q [$];
    logic he = 1'b0;
    int err_total = 0;
    int checks = 0;
    // Row: accept expected, word index (7 is none), mask on that word.
    hptd_row_t rows [15] = '{20'hD0001, 20'h08000, 20'h00010, 20'h00001, 20'h12000,
        20'h20001, 20'h32000, 20'h31000, 20'h30100, 20'h30001, 20'h40100,
        20'h40001, 20'h50002, 20'h60001, 20'hF0000};
    hptd_link_if lk();
    hptd_link_if lk2();
    // Host and decoder joined; a second decoder faces the hand driver.
    hptd_host i_hptd_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(lk.host),
        .addr_i(addr), .wdata_i(wdat), .wr_i(wr), .rd_i(rd), .rdata_o(rdat));
    hptd_dev i_hptd_dev (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(lk.dev),
        .heater_en_o(ht[0]), .control_address_register_o(ctl[0]),
        .control_status_housekeeping_word_o(hk[0]), .accept_o(acc[0]), .reject_o(rej[0]));
    hptd_dev i_hptd_dev_2 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(lk2.dev),
        .heater_en_o(ht[1]), .control_address_register_o(ctl[1]),
        .control_status_housekeeping_word_o(hk[1]), .accept_o(acc[1]), .reject_o(rej[1]));
    hptd_properties i_hptd_properties (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .valid(lk.valid), .last(lk.last), .restart(lk.restart), .data(lk.data),
        .heater_en_o(ht[0]), .control_address_register_o(ctl[0]),
        .control_status_housekeeping_word_o(hk[0]), .accept_o(acc[0]), .reject_o(rej[0]));
    // Clock of 40 ns period.
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // Words the host puts on the wire are kept for comparison.
    always @(posedge clk_sys_i) begin
        if (lk.valid === 1'b1) q.push_back(lk.data);
    end
    task automatic ck(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 ck(rdat, exp);
    endtask
    // Builds a packet with its checksum; a mask on word 6 spoils the sum.
    task automatic build(input hptd_row_t r, input logic [10:0] s);
        logic [15:0] cs;
        cs = CKSUM_SEED;
        pk = '{{VERSION, TC_TYPE, DFH_FLAG, APID, CATEGORY}, {SEQ_FLAGS, SEQ_SOURCE, s},
            LENGTH, {SVC_VERSION, CKSUM_FLAG, ACK, PKT_TYPE}, {SUBTYPE, PAD}, DATA_OFF, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            if (r.ix == i) pk[i] = pk[i] ^ r.mk;
            cs = {cs[14:0], cs[15]} ^ pk[i];
        end
        pk[6] = (r.ix == 3'h6) ? cs ^ r.mk : cs;
    endtask
    // Released data shows the inverse so stale words cannot pass.
    task automatic send2();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_sys_i);
            lk2.valid <= 1'b1;
            lk2.data <= pk[i];
            lk2.last <= (i == 6);
        end
        @(posedge clk_sys_i);
        lk2.valid <= 1'b0;
        lk2.last <= 1'b0;
        lk2.data <= ~pk[6];
        #1;
    endtask
    // Bounded wait for sel: 0 accept pulse, 1 reject pulse, 2 heater off.
    task automatic wacc(input int sel = 0);
        for (int n = 0; (sel == 0 ? acc[0] : (sel == 1 ? rej[0] : ~ht[0])) !== 1'b1; n++) begin
            if (n == 30) begin
                err_total++;
                wrap_up();
            end
            @(posedge clk_sys_i);
            #1;
        end
    endtask
    // Reset, the packet table, then host cases by hand.
    initial begin
        lk2.valid = 1'b0;
        lk2.last = 1'b0;
        lk2.restart = 1'b0;
        lk2.data = 16'h0000;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 ck({13'h0, ht[0], ctl[0][14], hk[0][9]}, 16'h0000);
        foreach (rows[k]) begin
            build(rows[k], 11'(k));
            if (rows[k].ok) he = pk[5][0];
            send2();
            ck({13'h0, acc[1], rej[1], ht[1]}, {13'h0, rows[k].ok, !rows[k].ok, he});
            ck(ctl[1], {1'b0, he, 14'h0000});
            ck(hk[1], {6'h00, he, 9'h000});
        end
        q.delete();
        wreg(REG_CMD, 16'h0001);
        wacc();
        build(20'h50001, 11'h000);
        foreach (pk[i]) ck(q[i], pk[i]);
        ck({15'h0, ht[0]}, 16'h0001);
        rchk(REG_SEQ, 16'h0001);
        q.delete();
        wreg(REG_CMD, 16'h0000);
        wreg(REG_CMD, 16'h0001);
        wacc();
        build(20'h00000, 11'h001);
        ck(q[1], pk[1]);
        ck(q[6], pk[6]);
        rchk(REG_STAT, 16'h0002);
        wreg(REG_STAT, 16'h0002);
        rchk(REG_STAT, 16'h0000);
        rchk(4'hF, 16'h0000);
        ck(16'(q.size()), 16'h0007);
        ck({15'h0, ht[0]}, 16'h0000);
        wreg(REG_CMD, 16'h0001);
        wacc();
        wreg(REG_CMD, 16'h8000);
        wacc(2);
        ck({15'h0, ht[0]}, 16'h0000);
        // A restart in mid-packet must leave the rest of that packet rejected.
        wreg(REG_CMD, 16'h0001);
        wreg(REG_CMD, 16'h8000);
        wacc(1);
        ck({14'h0, acc[0], ht[0]}, 16'h0000);
        wreg(REG_CMD, 16'h0001);
        wacc();
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        // Three edges, so the heater drop lies wholly inside the disabled window.
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 ck({15'h0, ht[0]}, 16'h0000);
        rchk(REG_SEQ, 16'h0000);
        wrap_up();
    end
endmodule // tb_heater_power_telecommand_decoder
